/* File: amd_decoder.sv */
// How it works
// - 0x0000-0x003F selects the I/O register page.
// - 0x0080-0x00FF selects the 128-byte RAM.
// - 0x7800-0x7FEE selects the 2031-byte user flash.
// - 0x7FEF alone selects the factory clock-trim byte, not user flash.
// - 0xF000-0xF2EF selects the 752-byte monitor ROM.
// - unimplemented addresses raise an illegal-address reset pulse.
// - 0xFE03-0xFE06 and 0xFE09 are reserved, flagged on reserved_o; they raise no illegal-address reset.
// - 0xFE00, 0xFE01, 0xFE02 select halt status, reset cause, halt flag control.
// - 0xFE08 flash control, 0xFE0C/0xFE0D breakpoint address high/low.
// - 0xFE0E breakpoint status, 0xFE0F low voltage, 0xFFF0 protect, 0xFFFF watchdog.
// - 14 bytes of user vectors in flash, apart from the main array.
`include "amd_cfg.svh"
module amd_decoder
  import amd_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic nrst_i,
  // cpu bus
  input wire logic [15:0] addr_i,
  input wire logic valid_i,
  input wire logic write_i,
  // selects
  output amd_sel_t sel_o,
  output logic illegal_rst_o,
  output logic reserved_o
);
  amd_state_t state_reg;
  amd_state_t state_next;
  logic in_vec;
  logic [15:0] a;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  always_comb begin
    a = addr_i;
    state_next = '0;
    in_vec = (a >= `AMD_VEC_LO) && (a <= `AMD_VEC_HI);
    if (valid_i) begin
      // write_i is deliberately not used: same check for reads and writes
      if (a <= `AMD_IO_HI) begin
        state_next.sel.io = 1'b1;
      end else if ((a >= `AMD_RAM_LO) && (a <= `AMD_RAM_HI)) begin
        state_next.sel.ram = 1'b1;
      end else if ((a >= `AMD_FLASH_LO) && (a <= `AMD_FLASH_HI)) begin
        state_next.sel.flash = 1'b1;
      end else if (a == `AMD_TRIM_ADDR) begin
        state_next.sel.trim = 1'b1;
      end else if ((a >= `AMD_ROM_LO) && (a <= `AMD_ROM_HI)) begin
        state_next.sel.rom = 1'b1;
      end else if (a == `AMD_HALT_STATUS) begin
        state_next.sel.halt_status = 1'b1;
      end else if (a == `AMD_RESET_CAUSE) begin
        state_next.sel.reset_cause = 1'b1;
      end else if (a == `AMD_HALT_FLAG_CTRL) begin
        state_next.sel.halt_flag_ctrl = 1'b1;
      end else if (((a >= `AMD_RSV_LO) && (a <= `AMD_RSV_HI)) || (a == `AMD_RSV_SINGLE)) begin
        state_next.reserved = 1'b1;
      end else if (a == `AMD_FLASH_CTRL) begin
        state_next.sel.flash_ctrl = 1'b1;
      end else if (a == `AMD_BRK_HIGH) begin
        state_next.sel.brk_high = 1'b1;
      end else if (a == `AMD_BRK_LOW) begin
        state_next.sel.brk_low = 1'b1;
      end else if (a == `AMD_BRK_STATUS) begin
        state_next.sel.brk_status = 1'b1;
      end else if (a == `AMD_LOW_VOLTAGE) begin
        state_next.sel.low_voltage = 1'b1;
      end else if (a == `AMD_FLASH_PROTECT) begin
        state_next.sel.flash_protect = 1'b1;
      end else if (a == `AMD_WATCHDOG) begin
        state_next.sel.watchdog = 1'b1;
      end else if (in_vec) begin
        state_next.sel.vec = 1'b1;
      end else begin
        state_next.illegal = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sel_o = state_reg.sel;
  assign illegal_rst_o = state_reg.illegal;
  assign reserved_o = state_reg.reserved;

  // ----------------------------------------
  // checks: memories
  // ----------------------------------------
  property p_io;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i <= `AMD_IO_HI |=> sel_o.io && !illegal_rst_o;
  endproperty
  a_io: assert property (p_io) else $error("io page not selected");

  property p_ram;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i >= `AMD_RAM_LO && addr_i <= `AMD_RAM_HI |=> sel_o.ram && !illegal_rst_o;
  endproperty
  a_ram: assert property (p_ram) else $error("ram not selected");

  property p_flash;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i >= `AMD_FLASH_LO && addr_i <= `AMD_FLASH_HI |=> sel_o.flash && !sel_o.trim;
  endproperty
  a_flash: assert property (p_flash) else $error("flash not selected");

  property p_trim;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_TRIM_ADDR |=> sel_o.trim && !sel_o.flash;
  endproperty
  a_trim: assert property (p_trim) else $error("trim byte misrouted");

  property p_rom;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i >= `AMD_ROM_LO && addr_i <= `AMD_ROM_HI |=> sel_o.rom;
  endproperty
  a_rom: assert property (p_rom) else $error("rom not selected");

  property p_vec;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i >= `AMD_VEC_LO && addr_i <= `AMD_VEC_HI |=> sel_o.vec && !illegal_rst_o;
  endproperty
  a_vec: assert property (p_vec) else $error("vector not selected");

  // ----------------------------------------
  // checks: unimplemented and reserved
  // ----------------------------------------
  property p_gap_a;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i >= `AMD_GAP_A_LO && addr_i <= `AMD_GAP_A_HI |=> illegal_rst_o && sel_o == '0;
  endproperty
  a_gap_a: assert property (p_gap_a) else $error("low gap access not caught");

  property p_gap_b;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i >= `AMD_GAP_B_LO && addr_i <= `AMD_GAP_B_HI |=> illegal_rst_o && sel_o == '0;
  endproperty
  a_gap_b: assert property (p_gap_b) else $error("middle gap access not caught");

  property p_gap_c;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i >= `AMD_GAP_C_LO && addr_i <= `AMD_GAP_C_HI |=> illegal_rst_o && sel_o == '0;
  endproperty
  a_gap_c: assert property (p_gap_c) else $error("upper gap access not caught");

  property p_gap_d;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i >= `AMD_GAP_D_LO && addr_i <= `AMD_GAP_D_HI |=> illegal_rst_o && sel_o == '0;
  endproperty
  a_gap_d: assert property (p_gap_d) else $error("rom gap access not caught");

  property p_gap_e;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i >= `AMD_GAP_E_LO && addr_i <= `AMD_GAP_E_HI |=> illegal_rst_o && sel_o == '0;
  endproperty
  a_gap_e: assert property (p_gap_e) else $error("high page gap access not caught");

  property p_holes;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && (addr_i == `AMD_HOLE_A || (addr_i >= `AMD_HOLE_B_LO && addr_i <= `AMD_HOLE_B_HI))
      |=> illegal_rst_o && sel_o == '0;
  endproperty
  a_holes: assert property (p_holes) else $error("high page hole not caught");

  property p_ill_cause;
    @(posedge mclk_i) disable iff (!nrst_i)
      illegal_rst_o |-> $past(valid_i);
  endproperty
  a_ill_cause: assert property (p_ill_cause) else $error("illegal reset without access");

  property p_ill_alone;
    @(posedge mclk_i) disable iff (!nrst_i)
      illegal_rst_o |-> sel_o == '0 && !reserved_o;
  endproperty
  a_ill_alone: assert property (p_ill_alone) else $error("illegal reset with a select");

  property p_reserved;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && ((addr_i >= `AMD_RSV_LO && addr_i <= `AMD_RSV_HI) || addr_i == `AMD_RSV_SINGLE)
      |=> reserved_o && !illegal_rst_o;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved not flagged");

  property p_rsv_cause;
    @(posedge mclk_i) disable iff (!nrst_i)
      reserved_o |-> $past(valid_i);
  endproperty
  a_rsv_cause: assert property (p_rsv_cause) else $error("reserved flag without access");

  property p_rsv_alone;
    @(posedge mclk_i) disable iff (!nrst_i)
      reserved_o |-> sel_o == '0 && !illegal_rst_o;
  endproperty
  a_rsv_alone: assert property (p_rsv_alone) else $error("reserved flag with a select");

  // ----------------------------------------
  // checks: system registers
  // ----------------------------------------
  property p_halt_status;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_HALT_STATUS |=> sel_o.halt_status;
  endproperty
  a_halt_status: assert property (p_halt_status) else $error("halt status not selected");

  property p_reset_cause;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_RESET_CAUSE |=> sel_o.reset_cause && !illegal_rst_o;
  endproperty
  a_reset_cause: assert property (p_reset_cause) else $error("reset cause not selected");

  property p_halt_flag;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_HALT_FLAG_CTRL |=> sel_o.halt_flag_ctrl;
  endproperty
  a_halt_flag: assert property (p_halt_flag) else $error("halt flag control not selected");

  property p_flash_ctrl;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_FLASH_CTRL |=> sel_o.flash_ctrl;
  endproperty
  a_flash_ctrl: assert property (p_flash_ctrl) else $error("flash control not selected");

  property p_brk_high;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_BRK_HIGH |=> sel_o.brk_high && !sel_o.brk_low;
  endproperty
  a_brk_high: assert property (p_brk_high) else $error("breakpoint high misrouted");

  property p_brk;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_BRK_LOW |=> sel_o.brk_low && !sel_o.brk_high;
  endproperty
  a_brk: assert property (p_brk) else $error("breakpoint low misrouted");

  property p_brk_status;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_BRK_STATUS |=> sel_o.brk_status;
  endproperty
  a_brk_status: assert property (p_brk_status) else $error("breakpoint status not selected");

  property p_low_voltage;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_LOW_VOLTAGE |=> sel_o.low_voltage;
  endproperty
  a_low_voltage: assert property (p_low_voltage) else $error("low voltage status not selected");

  property p_protect;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_FLASH_PROTECT |=> sel_o.flash_protect && !sel_o.vec;
  endproperty
  a_protect: assert property (p_protect) else $error("flash protect misrouted");

  property p_wdog;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && addr_i == `AMD_WATCHDOG |=> sel_o.watchdog && !sel_o.vec;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog misrouted");

  // ----------------------------------------
  // checks: one outcome per access
  // ----------------------------------------
  property p_onehot;
    @(posedge mclk_i) disable iff (!nrst_i)
      $onehot0({sel_o, illegal_rst_o, reserved_o});
  endproperty
  a_onehot: assert property (p_onehot) else $error("multiple selects");

  property p_idle;
    @(posedge mclk_i) disable iff (!nrst_i)
      !valid_i |=> sel_o == '0 && !illegal_rst_o && !reserved_o;
  endproperty
  a_idle: assert property (p_idle) else $error("select without access");

  property p_any_access;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i |=> $countones({sel_o, illegal_rst_o, reserved_o}) == 1;
  endproperty
  a_any_access: assert property (p_any_access) else $error("access without an outcome");

  property p_sel_cause;
    @(posedge mclk_i) disable iff (!nrst_i)
      sel_o != '0 |-> $past(valid_i);
  endproperty
  a_sel_cause: assert property (p_sel_cause) else $error("select without access");

  property p_rw_same;
    @(posedge mclk_i) disable iff (!nrst_i)
      valid_i && $past(valid_i) && addr_i == $past(addr_i) && write_i != $past(write_i)
      |=> {sel_o, illegal_rst_o, reserved_o} == $past({sel_o, illegal_rst_o, reserved_o});
  endproperty
  a_rw_same: assert property (p_rw_same) else $error("read and write decoded apart");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_ram_write: cover property (@(posedge mclk_i) disable iff (!nrst_i) valid_i && write_i && addr_i == `AMD_RAM_LO);
  c_illegal: cover property (@(posedge mclk_i) disable iff (!nrst_i) illegal_rst_o);
  c_reserved: cover property (@(posedge mclk_i) disable iff (!nrst_i) reserved_o);
  c_rom_then_flash: cover property (@(posedge mclk_i) disable iff (!nrst_i) sel_o.rom ##1 sel_o.flash);
endmodule : amd_decoder

/* File: amd_cfg.svh */
`ifndef AMD_CFG_SVH
`define AMD_CFG_SVH
// ----------------------------------------
// region bounds
// ----------------------------------------
`define AMD_IO_LO 16'h0000
`define AMD_IO_HI 16'h003F
`define AMD_RAM_LO 16'h0080
`define AMD_RAM_HI 16'h00FF
`define AMD_FLASH_LO 16'h7800
`define AMD_FLASH_HI 16'h7FEE
`define AMD_TRIM_ADDR 16'h7FEF
`define AMD_ROM_LO 16'hF000
`define AMD_ROM_HI 16'hF2EF
`define AMD_VEC_LO 16'hFFF1
`define AMD_VEC_HI 16'hFFFE
// ----------------------------------------
// unimplemented gaps
// ----------------------------------------
`define AMD_GAP_A_LO 16'h0040
`define AMD_GAP_A_HI 16'h007F
`define AMD_GAP_B_LO 16'h0100
`define AMD_GAP_B_HI 16'h77FF
`define AMD_GAP_C_LO 16'h7FF0
`define AMD_GAP_C_HI 16'hEFFF
`define AMD_GAP_D_LO 16'hF2F0
`define AMD_GAP_D_HI 16'hFDFF
`define AMD_GAP_E_LO 16'hFE10
`define AMD_GAP_E_HI 16'hFFEF
`define AMD_HOLE_A 16'hFE07
`define AMD_HOLE_B_LO 16'hFE0A
`define AMD_HOLE_B_HI 16'hFE0B
// ----------------------------------------
// high-page system registers
// ----------------------------------------
`define AMD_HALT_STATUS 16'hFE00
`define AMD_RESET_CAUSE 16'hFE01
`define AMD_HALT_FLAG_CTRL 16'hFE02
`define AMD_RSV_LO 16'hFE03
`define AMD_RSV_HI 16'hFE06
`define AMD_FLASH_CTRL 16'hFE08
`define AMD_RSV_SINGLE 16'hFE09
`define AMD_BRK_HIGH 16'hFE0C
`define AMD_BRK_LOW 16'hFE0D
`define AMD_BRK_STATUS 16'hFE0E
`define AMD_LOW_VOLTAGE 16'hFE0F
`define AMD_FLASH_PROTECT 16'hFFF0
`define AMD_WATCHDOG 16'hFFFF
`endif

/* File: amd_pkg.sv */
package amd_pkg;
  // ----------------------------------------
  // select vector, one-hot or all zero
  // ----------------------------------------
  typedef struct packed {
    logic io;
    logic ram;
    logic flash;
    logic trim;
    logic rom;
    logic vec;
    logic halt_status;
    logic reset_cause;
    logic halt_flag_ctrl;
    logic flash_ctrl;
    logic brk_high;
    logic brk_low;
    logic brk_status;
    logic low_voltage;
    logic flash_protect;
    logic watchdog;
  } amd_sel_t;

  typedef struct packed {
    amd_sel_t sel;
    logic illegal;
    logic reserved;
  } amd_state_t;
endpackage : amd_pkg

/* File: amd_cpu_model.sv */
module amd_cpu_model (
  // clock
  input wire logic mclk_i,
  // cpu bus out
  output logic [15:0] addr_o,
  output logic valid_o,
  output logic write_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // cpu side of the bus, driven by the caller at the falling edge
  // ----------------------------------------
  initial begin
    addr_o = 16'h0000;
    valid_o = 1'b0;
    write_o = 1'b0;
  end
  // reserved addresses only when the bench asks for them
  task automatic access(input logic [15:0] a, input logic wr);
    addr_o = a;
    valid_o = 1'b1;
    write_o = wr;
  endtask : access
  // released bus shows the inverse of the last address
  task automatic idle();
    valid_o = 1'b0;
    addr_o = ~addr_o;
  endtask : idle
endmodule : amd_cpu_model

/* File: amd_decoder_tb.sv */
`define TB_CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module amd_decoder_tb import amd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i;
  logic nrst_i;
  logic [15:0] addr_i;
  logic valid_i;
  logic write_i;
  amd_sel_t sel_o;
  logic illegal_rst_o;
  logic reserved_o;
  int error_cnt = 0;
  int check_count = 0;
  logic wr_tgl = 1'b0;
  amd_decoder u_amd_decoder (.mclk_i(mclk_i), .nrst_i(nrst_i), .addr_i(addr_i), .valid_i(valid_i),
    .write_i(write_i), .sel_o(sel_o), .illegal_rst_o(illegal_rst_o), .reserved_o(reserved_o));
  amd_cpu_model u_amd_cpu_model (.mclk_i(mclk_i), .addr_o(addr_i), .valid_o(valid_i), .write_o(write_i));
  // ----------------------------------------
  // clock and verdict
  // ----------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  task automatic stop_test();
    if (error_cnt == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // one access, checked one cycle later; idx is the select bit, -1 none
  // ----------------------------------------
  task automatic chk(input logic [15:0] a, input int idx, input logic ill, input logic rsv);
    amd_sel_t exp;
    exp = (idx < 0) ? 16'h0000 : (16'h0001 << idx);
    wr_tgl = ~wr_tgl;
    u_amd_cpu_model.access(a, wr_tgl);
    @(negedge mclk_i);
    `TB_CHK(sel_o, exp)
    `TB_CHK(illegal_rst_o, ill)
    `TB_CHK(reserved_o, rsv)
  endtask : chk
  task automatic t_memories();
    chk(16'h0000, 15, 1'b0, 1'b0);
    chk(16'h003F, 15, 1'b0, 1'b0);
    chk(16'h0080, 14, 1'b0, 1'b0);
    chk(16'h00FF, 14, 1'b0, 1'b0);
    chk(16'h7800, 13, 1'b0, 1'b0);
    chk(16'h7FEE, 13, 1'b0, 1'b0);
    chk(16'h7FEF, 12, 1'b0, 1'b0);
    chk(16'hF000, 11, 1'b0, 1'b0);
    chk(16'hF2EF, 11, 1'b0, 1'b0);
    chk(16'hFFF1, 10, 1'b0, 1'b0);
    chk(16'hFFF2, 10, 1'b0, 1'b0);
    chk(16'hFFFE, 10, 1'b0, 1'b0);
  endtask : t_memories
  task automatic t_illegal();
    chk(16'h0040, -1, 1'b1, 1'b0);
    chk(16'h007F, -1, 1'b1, 1'b0);
    chk(16'h0100, -1, 1'b1, 1'b0);
    chk(16'h7FF0, -1, 1'b1, 1'b0);
    chk(16'hF2F0, -1, 1'b1, 1'b0);
    chk(16'hFE07, -1, 1'b1, 1'b0);
    chk(16'hFE0B, -1, 1'b1, 1'b0);
  endtask : t_illegal
  task automatic t_reserved();
    chk(16'hFE03, -1, 1'b0, 1'b1);
    chk(16'hFE06, -1, 1'b0, 1'b1);
    chk(16'hFE09, -1, 1'b0, 1'b1);
  endtask : t_reserved
  task automatic t_sysregs();
    chk(16'hFE00, 9, 1'b0, 1'b0);
    chk(16'hFE01, 8, 1'b0, 1'b0);
    chk(16'hFE02, 7, 1'b0, 1'b0);
    chk(16'hFE08, 6, 1'b0, 1'b0);
    chk(16'hFE0C, 5, 1'b0, 1'b0);
    chk(16'hFE0D, 4, 1'b0, 1'b0);
    chk(16'hFE0E, 3, 1'b0, 1'b0);
    chk(16'hFE0F, 2, 1'b0, 1'b0);
    chk(16'hFFF0, 1, 1'b0, 1'b0);
    chk(16'hFFFF, 0, 1'b0, 1'b0);
  endtask : t_sysregs
  task automatic t_rw_alike();
    chk(16'h0040, -1, 1'b1, 1'b0);
    chk(16'h0040, -1, 1'b1, 1'b0);
    chk(16'h0080, 14, 1'b0, 1'b0);
    chk(16'h0080, 14, 1'b0, 1'b0);
  endtask : t_rw_alike
  task automatic t_reset();
    u_amd_cpu_model.access(16'h0040, 1'b0);
    @(negedge mclk_i);
    `TB_CHK(illegal_rst_o, 1'b1)
    nrst_i = 1'b0;
    @(negedge mclk_i);
    `TB_CHK({sel_o, illegal_rst_o, reserved_o}, 18'h00000)
    nrst_i = 1'b1;
    @(negedge mclk_i);
    `TB_CHK(illegal_rst_o, 1'b1)
  endtask : t_reset
  task automatic t_idle();
    u_amd_cpu_model.idle();
    @(negedge mclk_i);
    `TB_CHK({sel_o, illegal_rst_o, reserved_o}, 18'h00000)
  endtask : t_idle
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    nrst_i = 1'b0;
    repeat (20) @(negedge mclk_i);
    nrst_i = 1'b1;
    t_memories();
    t_illegal();
    t_reserved();
    t_sysregs();
    t_rw_alike();
    t_reset();
    t_idle();
    stop_test();
  end
  initial begin
    #5000;
    error_cnt++;
    stop_test();
  end
endmodule : amd_decoder_tb
